/* File: src/phr_port.sv */
`timescale 1ns/1ps
// Function
// - With chip select low the CPU moves data on the eight lines as strobes and address steer.
// - With chip select high the data lines are released from the next clock edge on.
// - Write data lands in the register when chip select or write strobe rises, whichever first.
// - A pending serial interrupt pulls the open-drain interrupt pin low; otherwise it is released.
// - A low reset pin clears all registers and returns the serial engine to its start state.
// - Serial timing comes from the internal oscillator, ready up to 550 us after enable is set.
// - The oscillator runs at 28.5 MHz typical, or 32 MHz on the glitch-free variant.
// - Eleven registers exist, four direct and seven reached through a pointer.
// - Indirect access writes the index to the pointer, then uses the indirect data field.
// - Pointer is at address 00, indirect field at 10, and index 02h is the clock low period.
// - Serial clock and data are open-drain outputs that are also sensed as inputs.
// - Data moves by single bytes through the data register, handshaken by interrupt or polling.
// - Write strobe and chip select both low load the bus data into the addressed register.
// - Read strobe and chip select both low drive the addressed register onto the data bus.
module phr_port #(
    parameter bit GLITCH_FREE_VARIANT = 1'b0,
    parameter int STARTUP_CYCLES      = phr_pkg::OSC_STARTUP_CYC
) (
    input  wire logic                    clock_in,
    input  wire logic                    rst_in,
    input  wire logic                    reset_n_in,
    input  wire logic                    chip_sel_n_in,
    input  wire logic                    rd_n_in,
    input  wire logic                    wr_n_in,
    input  wire logic                    reg_select_bit_low_in,
    input  wire logic                    reg_select_bit_high_in,
    input  wire logic [7:0]              data_in,
    output logic      [7:0]              data_out,
    output logic                         data_oe_out,
    output logic                         irq_n_out,
    output logic                         irq_n_oe_out,
    input  wire logic                    scl_in,
    output logic                         scl_out,
    output logic                         scl_oe_out,
    input  wire logic                    sda_in,
    output logic                         sda_out,
    output logic                         sda_oe_out,
    input  wire phr_pkg::phr_engine_in_t engine_in,
    output phr_pkg::phr_engine_cfg_t     engine_cfg_out,
    output logic                         engine_reset_out,
    output logic                         si_clear_out,
    output logic                         preset_write_out,
    output logic                         osc_tick_out,
    output logic                         osc_ready_out,
    output logic                         scl_level_out,
    output logic                         sda_level_out
);

    localparam int OSC_KHZ = GLITCH_FREE_VARIANT ? phr_pkg::OSC_GLITCH_KHZ
                                                 : phr_pkg::OSC_BASE_KHZ;
    localparam int CNT_W   = $clog2(STARTUP_CYCLES + 1);

    generate
        if (OSC_KHZ >= phr_pkg::CLK_KHZ || STARTUP_CYCLES < 1) begin : g_chk
            $error("Oscillator rate or startup count not supported");
        end
    endgenerate

    phr_pkg::phr_cycle_t cyc_q;
    phr_pkg::phr_cycle_t cyc_d;
    logic [1:0]  wr_sel_q;
    logic [7:0]  wr_data_q;
    logic        commit;
    logic        write_act;
    logic        read_act;
    logic [1:0]  sel;
    logic [7:0]  pointer_q;
    logic [7:0]  status_q;
    logic [7:0]  data_q;
    logic [7:0]  control_q;
    logic [7:0]  ind_q [phr_pkg::IND_COUNT];
    logic [7:0]  rd_mux;
    logic [7:0]  ind_rd;
    logic        soft_clr;
    logic [17:0] phase_q;
    logic [CNT_W-1:0] start_cnt_q;

    assign sel       = {reg_select_bit_high_in, reg_select_bit_low_in};
    assign write_act = !chip_sel_n_in && !wr_n_in;
    assign read_act  = !chip_sel_n_in && !rd_n_in && wr_n_in;
    // End of the active window is the first rising edge of either strobe
    assign commit    = (cyc_q == phr_pkg::CYC_WRITE) && !write_act;
    assign soft_clr  = !reset_n_in;

    always_comb begin
        cyc_d = phr_pkg::CYC_IDLE;
        if (write_act) begin
            cyc_d = phr_pkg::CYC_WRITE;
        end else if (read_act) begin
            cyc_d = phr_pkg::CYC_READ;
        end
    end

    always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            cyc_q <= phr_pkg::CYC_IDLE;
        end else begin
            cyc_q <= cyc_d;
        end
    end

    // Latch address and data every active cycle; last sample wins
    always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            wr_sel_q  <= 2'h0;
            wr_data_q <= 8'h00;
        end else if (write_act) begin
            wr_sel_q  <= sel;
            wr_data_q <= data_in;
        end
    end

    // Pointer shares address 00 with status, split by direction
    always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            pointer_q <= phr_pkg::POINTER_RESET;
        end else if (soft_clr) begin
            pointer_q <= phr_pkg::POINTER_RESET;
        end else if (commit && wr_sel_q == phr_pkg::SEL_STATUS_PTR) begin
            pointer_q <= wr_data_q & phr_pkg::POINTER_MASK;
        end
    end

    always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            status_q <= phr_pkg::STATUS_RESET;
        end else if (soft_clr) begin
            status_q <= phr_pkg::STATUS_RESET;
        end else begin
            status_q <= engine_in.status & phr_pkg::STATUS_MASK;
        end
    end

    // Engine capture and CPU write of the data byte
    always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            data_q <= phr_pkg::DATA_RESET;
        end else if (soft_clr) begin
            data_q <= phr_pkg::DATA_RESET;
        end else if (commit && wr_sel_q == phr_pkg::SEL_DATA) begin
            data_q <= wr_data_q;
        end else if (engine_in.rx_valid) begin
            data_q <= engine_in.rx_data;
        end
    end

    // Writing control clears the interrupt flag; a new request wins
    always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            control_q <= phr_pkg::CONTROL_RESET;
        end else if (soft_clr) begin
            control_q <= phr_pkg::CONTROL_RESET;
        end else begin
            if (commit && wr_sel_q == phr_pkg::SEL_CONTROL) begin
                control_q <= wr_data_q;
                control_q[phr_pkg::CTL_SI_BIT] <= 1'b0;
                if (!wr_data_q[phr_pkg::CTL_STOP_BIT] || engine_in.stop_done)
                begin
                    control_q[phr_pkg::CTL_STOP_BIT] <= 1'b0;
                end
            end else if (engine_in.stop_done) begin
                control_q[phr_pkg::CTL_STOP_BIT] <= 1'b0;
            end
            if (engine_in.si_set) begin
                control_q[phr_pkg::CTL_SI_BIT] <= 1'b1;
            end
        end
    end

    // Seven pointer-selected registers, one per entry
    generate
        for (genvar i = 0; i < phr_pkg::IND_COUNT; i++) begin : g_ind
            always_ff @(posedge clock_in or posedge rst_in) begin
                if (rst_in) begin
                    ind_q[i] <= phr_pkg::IND_RESET[i];
                end else if (soft_clr) begin
                    ind_q[i] <= phr_pkg::IND_RESET[i];
                end else if (commit && wr_sel_q == phr_pkg::SEL_INDIRECT
                             && pointer_q[2:0] == 3'(i)) begin
                    ind_q[i] <= wr_data_q;
                end
            end
        end
    endgenerate

    always_comb begin
        ind_rd = 8'h00;
        // Trigger register is write-only; unused index reads zero
        if (pointer_q[2:0] != phr_pkg::IDX_PRESET
            && pointer_q[2:0] < 3'(phr_pkg::IND_COUNT)) begin
            ind_rd = ind_q[pointer_q[2:0]];
        end
    end

    always_comb begin
        case (sel)
            phr_pkg::SEL_STATUS_PTR: rd_mux = status_q;
            phr_pkg::SEL_DATA:       rd_mux = data_q;
            phr_pkg::SEL_INDIRECT:   rd_mux = ind_rd;
            phr_pkg::SEL_CONTROL:    rd_mux = control_q;
            default:                 rd_mux = 8'h00;
        endcase
    end

    // Driven one cycle after the strobe is seen low; released likewise
    always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            data_out    <= 8'h00;
            data_oe_out <= 1'b0;
        end else begin
            data_out    <= read_act ? rd_mux : 8'h00;
            data_oe_out <= read_act;
        end
    end

    always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            irq_n_out        <= 1'b0;
            irq_n_oe_out     <= 1'b0;
            engine_reset_out <= 1'b1;
            si_clear_out     <= 1'b0;
            preset_write_out <= 1'b0;
        end else begin
            irq_n_out        <= 1'b0;
            irq_n_oe_out     <= control_q[phr_pkg::CTL_SI_BIT];
            engine_reset_out <= soft_clr;
            si_clear_out     <= commit && wr_sel_q == phr_pkg::SEL_CONTROL;
            preset_write_out <= commit && wr_sel_q == phr_pkg::SEL_INDIRECT
                                && pointer_q[2:0] == phr_pkg::IDX_PRESET;
        end
    end

    always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            engine_cfg_out <= '0;
        end else begin
            engine_cfg_out.control  <= control_q;
            engine_cfg_out.data     <= data_q;
            engine_cfg_out.count    <= ind_q[phr_pkg::IDX_COUNT];
            engine_cfg_out.own_addr <= ind_q[phr_pkg::IDX_OWN_ADDR];
            engine_cfg_out.scl_low  <= ind_q[phr_pkg::IDX_SCL_LOW];
            engine_cfg_out.scl_high <= ind_q[phr_pkg::IDX_SCL_HIGH];
            engine_cfg_out.timeout  <= ind_q[phr_pkg::IDX_TIMEOUT];
            engine_cfg_out.mode     <= ind_q[phr_pkg::IDX_MODE];
        end
    end

    // Open-drain: only ever pull low, lines sensed back
    always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            scl_out       <= 1'b0;
            sda_out       <= 1'b0;
            scl_oe_out    <= 1'b0;
            sda_oe_out    <= 1'b0;
            scl_level_out <= 1'b1;
            sda_level_out <= 1'b1;
        end else begin
            scl_out       <= 1'b0;
            sda_out       <= 1'b0;
            scl_oe_out    <= engine_in.scl_drive_low && !soft_clr;
            sda_oe_out    <= engine_in.sda_drive_low && !soft_clr;
            scl_level_out <= scl_in;
            sda_level_out <= sda_in;
        end
    end

    // Fractional accumulator stands in for the free-running oscillator
    always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            phase_q      <= 18'h00000;
            osc_tick_out <= 1'b0;
        end else if (!control_q[phr_pkg::CTL_ENABLE_BIT]) begin
            phase_q      <= 18'h00000;
            osc_tick_out <= 1'b0;
        end else if (phase_q + 18'(OSC_KHZ) >= 18'(phr_pkg::CLK_KHZ)) begin
            phase_q      <= phase_q + 18'(OSC_KHZ)
                            - 18'(phr_pkg::CLK_KHZ);
            osc_tick_out <= osc_ready_out;
        end else begin
            phase_q      <= phase_q + 18'(OSC_KHZ);
            osc_tick_out <= 1'b0;
        end
    end

    // Startup wait restarts whenever the engine is disabled
    always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            start_cnt_q   <= '0;
            osc_ready_out <= 1'b0;
        end else if (!control_q[phr_pkg::CTL_ENABLE_BIT]) begin
            start_cnt_q   <= '0;
            osc_ready_out <= 1'b0;
        end else if (start_cnt_q != CNT_W'(STARTUP_CYCLES)) begin
            start_cnt_q   <= start_cnt_q + CNT_W'(1);
            osc_ready_out <= 1'b0;
        end else begin
            osc_ready_out <= 1'b1;
        end
    end

endmodule : phr_port

/* File: src/phr_pkg.sv */
package phr_pkg;

    // Direct register select {high, low}
    localparam logic [1:0] SEL_STATUS_PTR = 2'h0;
    localparam logic [1:0] SEL_DATA       = 2'h1;
    localparam logic [1:0] SEL_INDIRECT   = 2'h2;
    localparam logic [1:0] SEL_CONTROL    = 2'h3;

    // Indirect space, indexed by the pointer
    localparam int          IND_COUNT    = 7;
    localparam logic [2:0]  IDX_COUNT    = 3'h0;
    localparam logic [2:0]  IDX_OWN_ADDR = 3'h1;
    localparam logic [2:0]  IDX_SCL_LOW  = 3'h2;
    localparam logic [2:0]  IDX_SCL_HIGH = 3'h3;
    localparam logic [2:0]  IDX_TIMEOUT  = 3'h4;
    localparam logic [2:0]  IDX_PRESET   = 3'h5;
    localparam logic [2:0]  IDX_MODE     = 3'h6;
    localparam logic [7:0]  IND_RESET [IND_COUNT] = '{
        8'h01, 8'hE0, 8'h9D, 8'h86, 8'hFF, 8'h00, 8'h00};

    // Reset values and masks of direct registers
    localparam logic [7:0] STATUS_RESET  = 8'hF8;
    localparam logic [7:0] POINTER_RESET = 8'h00;
    localparam logic [7:0] DATA_RESET    = 8'h00;
    localparam logic [7:0] CONTROL_RESET = 8'h00;
    localparam logic [7:0] STATUS_MASK   = 8'hFC;
    localparam logic [7:0] POINTER_MASK  = 8'h07;

    // Control register fields
    localparam int CTL_ACK_BIT    = 7;
    localparam int CTL_ENABLE_BIT = 6;
    localparam int CTL_START_BIT  = 5;
    localparam int CTL_STOP_BIT   = 4;
    localparam int CTL_SI_BIT     = 3;
    localparam int CTL_MODE_BIT   = 0;

    // Timing
    localparam int CLK_KHZ          = 125000;
    localparam int OSC_BASE_KHZ     = 28500;
    localparam int OSC_GLITCH_KHZ   = 32000;
    localparam int OSC_STARTUP_US   = 550;
    localparam int OSC_STARTUP_CYC  = OSC_STARTUP_US * (CLK_KHZ / 1000);

    typedef enum logic [1:0] {
        CYC_IDLE  = 2'b00,
        CYC_WRITE = 2'b01,
        CYC_READ  = 2'b10
    } phr_cycle_t;

    typedef struct packed {
        logic [7:0] status;
        logic       si_set;
        logic       stop_done;
        logic       rx_valid;
        logic [7:0] rx_data;
        logic       scl_drive_low;
        logic       sda_drive_low;
    } phr_engine_in_t;

    typedef struct packed {
        logic [7:0] control;
        logic [7:0] data;
        logic [7:0] count;
        logic [7:0] own_addr;
        logic [7:0] scl_low;
        logic [7:0] scl_high;
        logic [7:0] timeout;
        logic [7:0] mode;
    } phr_engine_cfg_t;

endpackage : phr_pkg

/* File: dv/phr_engine_model.sv */
`timescale 1ns/1ps
module phr_engine_model (
    input  wire logic                    si_req_in,
    input  wire logic [7:0]              status_in,
    input  wire logic                    pull_scl_in,
    input  wire logic                    pull_sda_in,
    input  wire logic                    scl_oe_in,
    input  wire logic                    sda_oe_in,
    input  wire logic                    irq_oe_in,
    output phr_pkg::phr_engine_in_t      engine_out,
    output logic                         scl_line_out,
    output logic                         sda_line_out,
    output logic                         irq_line_out
);
    // Pull-ups give the high level, any low driver wins
    assign scl_line_out = !scl_oe_in;
    assign sda_line_out = !sda_oe_in;
    assign irq_line_out = !irq_oe_in;
    // One-cycle request pulse, the handshake by interrupt
    always_comb begin
        engine_out               = '0;
        engine_out.status        = status_in;
        engine_out.si_set        = si_req_in;
        engine_out.scl_drive_low = pull_scl_in;
        engine_out.sda_drive_low = pull_sda_in;
    end
endmodule : phr_engine_model

/* File: dv/phr_port_checker.sv */
`timescale 1ns/1ps
module phr_port_checker (
    input  wire logic                     clock_in,
    input  wire logic                     rst_in,
    input  wire logic                     reset_n_in,
    input  wire logic                     chip_sel_n_in,
    input  wire logic                     rd_n_in,
    input  wire logic                     wr_n_in,
    input  wire logic                     data_oe_out,
    input  wire logic                     irq_n_out,
    input  wire logic                     reg_select_bit_low_in,
    input  wire logic                     reg_select_bit_high_in,
    input  wire logic                     irq_n_oe_out,
    input  wire logic                     scl_out,
    input  wire logic                     scl_oe_out,
    input  wire logic                     sda_out,
    input  wire logic                     sda_oe_out,
    input  wire logic                     engine_reset_out,
    input  wire logic                     osc_tick_out,
    input  wire logic                     osc_ready_out,
    input  wire logic [7:0]               data_in,
    input  wire phr_pkg::phr_engine_in_t  engine_in,
    input  wire phr_pkg::phr_engine_cfg_t engine_cfg_out
);
    default clocking @(posedge clock_in); endclocking
    default disable iff (rst_in);
    sequence s_si_raise;
        engine_in.si_set && chip_sel_n_in && reset_n_in ##1 reset_n_in;
    endsequence
    sequence s_data_wr;
        !chip_sel_n_in && !wr_n_in && reset_n_in && reg_select_bit_low_in
        && !reg_select_bit_high_in ##1 chip_sel_n_in && reset_n_in;
    endsequence
    property p_bus_release;
        chip_sel_n_in |=> !data_oe_out;
    endproperty
    property p_read_drive;
        !chip_sel_n_in && !rd_n_in && wr_n_in && reset_n_in |=> data_oe_out;
    endproperty
    property p_oe_cause;
        data_oe_out |-> $past(!chip_sel_n_in && !rd_n_in);
    endproperty
    property p_si_irq;
        s_si_raise |=> irq_n_oe_out;
    endproperty
    property p_dev_reset;
        !reset_n_in ##1 !reset_n_in |=> engine_reset_out && !irq_n_oe_out
            && !scl_oe_out && !sda_oe_out;
    endproperty
    property p_line_drive;
        reset_n_in |=> scl_oe_out == $past(engine_in.scl_drive_low)
            && sda_oe_out == $past(engine_in.sda_drive_low);
    endproperty
    property p_od_low;
        !irq_n_out && !scl_out && !sda_out;
    endproperty
    property p_wr_commit;
        s_data_wr |=> ##1 engine_cfg_out.data == $past(data_in, 3);
    endproperty
    property p_tick_ready;
        osc_tick_out |-> osc_ready_out;
    endproperty
    a_bus_release: assert property (p_bus_release)
        else $error("data bus driven while deselected");
    a_read_drive: assert property (p_read_drive)
        else $error("read not driven");
    a_oe_cause: assert property (p_oe_cause)
        else $error("data bus driven without read");
    a_si_irq: assert property (p_si_irq)
        else $error("interrupt not raised");
    a_dev_reset: assert property (p_dev_reset)
        else $error("device reset not applied");
    a_line_drive: assert property (p_line_drive)
        else $error("serial line drive mismatch");
    a_od_low: assert property (p_od_low)
        else $error("open-drain pin driven high");
    a_wr_commit: assert property (p_wr_commit)
        else $error("write data not committed");
    a_tick_ready: assert property (p_tick_ready)
        else $error("tick before oscillator ready");
endmodule : phr_port_checker

bind phr_port phr_port_checker i_phr_port_checker (.*);

/* File: dv/phr_port_tb.sv */
`timescale 1ns/1ps
module phr_port_tb;
    logic       clock_in, rst_in, reset_n_in, chip_sel_n_in, rd_n_in;
    logic       wr_n_in, reg_select_bit_low_in, reg_select_bit_high_in;
    logic [7:0] data_in, data_out, status, got;
    logic       data_oe_out, irq_n_out, irq_n_oe_out, scl_in, scl_out;
    logic       scl_oe_out, sda_in, sda_out, sda_oe_out, engine_reset_out;
    logic       osc_tick_out, osc_ready_out, scl_level_out, sda_level_out;
    logic       si_req, pull_scl, pull_sda, irq_line;
    logic       si_clear_out, preset_write_out;
    int         errors, tests_run, n;
    phr_pkg::phr_engine_in_t  engine_in;
    phr_pkg::phr_engine_cfg_t engine_cfg_out;
    logic [7:0] ind_exp [7] = '{8'h01, 8'hE0, 8'h9D, 8'h86, 8'hFF, 8'h00,
                                8'h00};

    // Startup count shortened so the run stays short
    phr_port #(.STARTUP_CYCLES(20)) i_phr_port (.*);
    phr_engine_model i_phr_engine_model (.si_req_in(si_req),
        .status_in(status), .pull_scl_in(pull_scl), .pull_sda_in(pull_sda),
        .scl_oe_in(scl_oe_out), .sda_oe_in(sda_oe_out),
        .irq_oe_in(irq_n_oe_out), .engine_out(engine_in),
        .scl_line_out(scl_in), .sda_line_out(sda_in),
        .irq_line_out(irq_line));

    initial begin
        clock_in = 1'b0;
        forever #4 clock_in = ~clock_in;
    end

    task automatic complete_run;
        $display("Errors %0d, checks %0d", errors, tests_run);
        if (errors == 0 && tests_run > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : complete_run

    task automatic check8(input logic [7:0] g, e, input string m);
        tests_run++;
        if (g !== e) begin
            errors++;
            $display("[FAIL] %0t %s: got %h exp %h", $time, m, g, e);
        end
    endtask : check8

    task automatic step;
        @(posedge clock_in);
        #1;
    endtask : step

    // Either strobe may end the cycle; the first rising one commits
    task automatic bus_write(input logic [1:0] s, input logic [7:0] d,
                             input bit cs_first);
        step();
        {reg_select_bit_high_in, reg_select_bit_low_in} = s;
        data_in = d;
        step();
        chip_sel_n_in = 1'b0;
        wr_n_in = 1'b0;
        step();
        if (cs_first) chip_sel_n_in = 1'b1;
        else wr_n_in = 1'b1;
        step();
        chip_sel_n_in = 1'b1;
        wr_n_in = 1'b1;
    endtask : bus_write

    task automatic bus_read(input logic [1:0] s, output logic [7:0] d);
        step();
        {reg_select_bit_high_in, reg_select_bit_low_in} = s;
        step();
        chip_sel_n_in = 1'b0;
        rd_n_in = 1'b0;
        step();
        d = data_out;
        check8({7'h0, data_oe_out}, 8'h01, "read drive");
        chip_sel_n_in = 1'b1;
        rd_n_in = 1'b1;
        step();
        check8({7'h0, data_oe_out}, 8'h00, "bus release");
    endtask : bus_read

    initial begin
        {rst_in, reset_n_in, chip_sel_n_in, rd_n_in, wr_n_in} = 5'h1F;
        {reg_select_bit_high_in, reg_select_bit_low_in} = 2'h0;
        {data_in, status} = {8'h00, 8'hF8};
        {si_req, pull_scl, pull_sda} = 3'h0;
        errors = 0;
        tests_run = 0;
        repeat (20) @(posedge clock_in);
        #1 rst_in = 1'b0;
        bus_read(phr_pkg::SEL_STATUS_PTR, got);
        check8(got, 8'hF8, "status");
        for (int i = 0; i < 7; i++) begin
            bus_write(phr_pkg::SEL_STATUS_PTR, 8'(i), i[0]);
            bus_read(phr_pkg::SEL_INDIRECT, got);
            check8(got, ind_exp[i], "indirect reset");
            bus_write(phr_pkg::SEL_INDIRECT, 8'hC0 + 8'(i), 1'b0);
            check8({7'h0, preset_write_out}, 8'(i == 5), "preset");
            bus_read(phr_pkg::SEL_INDIRECT, got);
            check8(got, i == 5 ? 8'h00 : 8'hC0 + 8'(i), "indirect");
        end
        bus_read(phr_pkg::SEL_STATUS_PTR, got);
        check8(got, 8'hF8, "status not pointer");
        check8(engine_cfg_out.scl_low, 8'hC2, "low period");
        bus_write(phr_pkg::SEL_DATA, 8'hA5, 1'b1);
        bus_read(phr_pkg::SEL_DATA, got);
        check8(got, 8'hA5, "data");
        bus_write(phr_pkg::SEL_CONTROL, 8'h40, 1'b1);
        check8({7'h0, si_clear_out}, 8'h01, "si clear");
        check8({7'h0, osc_ready_out}, 8'h00, "early ready");
        for (n = 0; n < 100 && osc_ready_out !== 1'b1; n++) step();
        check8(8'(n >= 15 && n < 100), 8'h01, "startup");
        n = 0;
        repeat (2000) begin
            step();
            n += int'(osc_tick_out);
        end
        check8(8'(n >= 455 && n <= 457), 8'h01, "tick rate");
        status = 8'h08;
        si_req = 1'b1;
        step();
        si_req = 1'b0;
        step();
        step();
        check8({7'h0, irq_line}, 8'h00, "irq low");
        bus_read(phr_pkg::SEL_CONTROL, got);
        check8(got, 8'h48, "request flag");
        bus_read(phr_pkg::SEL_STATUS_PTR, got);
        check8(got, 8'h08, "status mirror");
        bus_write(phr_pkg::SEL_CONTROL, 8'h40, 1'b0);
        step();
        check8({7'h0, irq_line}, 8'h01, "irq released");
        pull_scl = 1'b1;
        repeat (3) step();
        check8({6'h0, scl_in, scl_level_out}, 8'h00, "scl low");
        check8({6'h0, sda_in, sda_level_out}, 8'h03, "sda high");
        {pull_scl, pull_sda} = 2'h1;
        repeat (3) step();
        check8({6'h0, sda_in, sda_level_out}, 8'h00, "sda low");
        check8({6'h0, scl_in, scl_level_out}, 8'h03, "scl high");
        pull_sda = 1'b0;
        reset_n_in = 1'b0;
        repeat (3) step();
        check8({7'h0, engine_reset_out}, 8'h01, "engine reset");
        reset_n_in = 1'b1;
        bus_read(phr_pkg::SEL_DATA, got);
        check8(got, 8'h00, "data cleared");
        bus_read(phr_pkg::SEL_CONTROL, got);
        check8(got, 8'h00, "control cleared");
        bus_read(phr_pkg::SEL_INDIRECT, got);
        check8(got, 8'h01, "indirect cleared");
        complete_run();
    end
endmodule : phr_port_tb
